// file: wrt_regs.vh
// register offsets, field positions and reset values of the wrap timer
`ifndef WRT_REGS_VH
`define WRT_REGS_VH
// -------------------------------------------------------------
// byte offsets on the register bus
// -------------------------------------------------------------
`define WRT_OFF_STATUS_CONTROL 4'h0
`define WRT_OFF_CLOCK_CONFIG 4'h4
`define WRT_OFF_COUNT_VALUE 4'h8
`define WRT_OFF_WRAP_LIMIT 4'hc
// -------------------------------------------------------------
// field positions
// -------------------------------------------------------------
`define WRT_BIT_OVF 7
`define WRT_BIT_OVF_IRQ_EN 6
`define WRT_BIT_CNT_RESET 5
`define WRT_BIT_HALT 4
`define WRT_SRC_HI 5
`define WRT_SRC_LO 4
`define WRT_PS_HI 3
`define WRT_PS_LO 0
// -------------------------------------------------------------
// reset values and encodings
// -------------------------------------------------------------
`define WRT_RST_HALT 1'b1
`define WRT_RST_SRC 2'h0
`define WRT_RST_PS 4'h0
`define WRT_RST_COUNT 8'h00
`define WRT_RST_WRAP 8'h00
`define WRT_SRC_BUS 2'h0
`define WRT_SRC_FIXED 2'h1
`define WRT_SRC_EXT_FALL 2'h2
`define WRT_SRC_EXT_RISE 2'h3
`define WRT_PS_MAX 4'h8
`define WRT_RESP_OKAY 2'h0
`define WRT_RESP_SLVERR 2'h2
`endif

// file: wrt_wrap_timer.v
// 8-bit wrap timer with prescaler, source select and axi4-lite registers
//
// Overview of operation
// R1 - overflow flag bit 7 sets when counter wraps from limit to zero
// R2 - flag clears on a status read with flag set, then a write of 0
// R3 - counter reset bit write of 1 or wrap limit write also clears flag
// R4 - irq enable in bit 6; irq asserted while enable and flag both 1
// R5 - software clears flag before setting irq enable
// R6 - write 1 to bit 5 zeroes counter and flag; reads as 0
// R7 - halt bit 4 freezes counter; clearing resumes from held value
// R8 - reset sets halt bit, counter idle until software clears it
// R9 - status bits 3:0 and config bits 7:6 read zero
// R10 - source field 5:4: bus, fixed clock, ext falling, ext rising
// R11 - changing source does not clear counter
// R12 - reset clears source field, selecting the bus clock
// R13 - prescale field 3:0 divides source by two to the code
// R14 - codes above 8 divide by 256
// R15 - changing prescale does not clear counter
// R16 - reset clears prescale field to divide-by-1
// R17 - counter counts to wrap limit then wraps; limit zero free-runs
// R18 - wrap limit write zeroes counter and flag; reset clears limit
// R19 - count register read-only, writes ignored, reset clears it
// R20 - external input no faster than a quarter of bus clock
// R21 - overflow between flag read and clearing write keeps the flag
// R22 - external input synchronised, selected edge gives one-cycle enable
`timescale 1ns/1ns
`default_nettype none
`include "wrt_regs.vh"

module wrt_wrap_timer #(
   parameter PS_WIDTH = 8
) (
   input wire aclk,
   input wire aresetn,
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire fixed_frequency_clock,
   input wire external_count_input,
   output reg overflow_irq
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   reg overflow_flag_r;
   reg overflow_irq_enable_r;
   reg counter_halt_bit_r;
   reg [1:0] count_source_select_r;
   reg [3:0] prescale_select_r;
   reg [7:0] count_r;
   reg [7:0] wrap_limit_value_r;
   reg [PS_WIDTH-1:0] prescale_r;
   reg clear_armed_r;
   reg [2:0] ext_sync_r;
   reg [2:0] fix_sync_r;
   reg [3:0] awaddr_r;
   reg aw_held_r;
   reg [31:0] wdata_r;
   reg [3:0] wstrb_r;
   reg w_held_r;

   // ------------------------------------------------------------
   // source selection and prescaler
   // ------------------------------------------------------------
   wire ext_rise = ext_sync_r[1] & ~ext_sync_r[2];
   wire ext_fall = ~ext_sync_r[1] & ext_sync_r[2];
   wire fix_rise = fix_sync_r[1] & ~fix_sync_r[2];
   reg src_tick;
   reg [PS_WIDTH-1:0] ps_mask;
   wire [PS_WIDTH-1:0] prescale_inc = prescale_r + {{(PS_WIDTH-1){1'b0}}, 1'b1};

   // pick the qualifying source edge
   always @* begin
      case (count_source_select_r) // [R10]
         `WRT_SRC_BUS: src_tick = 1'b1;
         `WRT_SRC_FIXED: src_tick = fix_rise;
         `WRT_SRC_EXT_FALL: src_tick = ext_fall; // [R22]
         `WRT_SRC_EXT_RISE: src_tick = ext_rise; // [R22]
         default: src_tick = 1'b1;
      endcase
   end

   // low bits of the prescaler that must be all ones for a count
   always @* begin
      if (prescale_select_r >= `WRT_PS_MAX) begin
         ps_mask = {PS_WIDTH{1'b1}}; // [R14]
      end else begin
         ps_mask = ~({PS_WIDTH{1'b1}} << prescale_select_r); // [R13]
      end
   end

   // prescaler is not cleared on config change, so the next
   // count may come early; counter value itself is kept
   wire count_tick = src_tick & ~counter_halt_bit_r & ((prescale_r & ps_mask) == ps_mask); // [R7]
   // a zero limit means free running: the wrap then comes at all ones,
   // which is also where the flag must set; comparing against zero
   // itself would pin the counter at zero and flag every tick
   wire [7:0] wrap_at = (wrap_limit_value_r == 8'h00) ? 8'hff : wrap_limit_value_r; // [R17]
   wire wrap_now = count_tick & (count_r == wrap_at); // [R17]

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   // a write acts once, at the edge where both halves are held and the
   // response is raised; decoding raw valids would apply it twice
   wire wr_go = aw_held_r & w_held_r & ~s_axi_bvalid;
   wire [3:0] wr_addr = awaddr_r;
   wire [31:0] wr_data = wdata_r;
   wire [3:0] wr_strb = wstrb_r;
   // only byte lane 0 carries register bits
   wire wr_lane0 = wr_go & wr_strb[0];
   wire wr_sc = wr_lane0 & (wr_addr == `WRT_OFF_STATUS_CONTROL);
   wire wr_clk = wr_lane0 & (wr_addr == `WRT_OFF_CLOCK_CONFIG);
   wire wr_mod = wr_lane0 & (wr_addr == `WRT_OFF_WRAP_LIMIT);
   wire wr_known = (wr_addr == `WRT_OFF_STATUS_CONTROL) | (wr_addr == `WRT_OFF_CLOCK_CONFIG) |
                   (wr_addr == `WRT_OFF_COUNT_VALUE) | (wr_addr == `WRT_OFF_WRAP_LIMIT);
   wire rd_go = s_axi_arvalid & s_axi_arready;
   wire rd_sc = rd_go & (s_axi_araddr == `WRT_OFF_STATUS_CONTROL);
   wire cnt_reset = wr_sc & wr_data[`WRT_BIT_CNT_RESET]; // [R6]
   // flag-clear write only counts when armed by a read that saw it set
   wire flag_clear = wr_sc & ~wr_data[`WRT_BIT_OVF] & clear_armed_r; // [R2]

   // ------------------------------------------------------------
   // read data
   // ------------------------------------------------------------
   // unmapped offsets read as zero with an error response
   reg [7:0] rd_byte;
   reg rd_known;
   always @* begin
      rd_known = 1'b1;
      case (s_axi_araddr)
         `WRT_OFF_STATUS_CONTROL: rd_byte = {overflow_flag_r, overflow_irq_enable_r, 1'b0,
                                             counter_halt_bit_r, 4'h0}; // [R6] [R9]
         `WRT_OFF_CLOCK_CONFIG: rd_byte = {2'b00, count_source_select_r, prescale_select_r}; // [R9]
         `WRT_OFF_COUNT_VALUE: rd_byte = count_r; // [R19]
         `WRT_OFF_WRAP_LIMIT: rd_byte = wrap_limit_value_r;
         default: begin
            rd_byte = 8'h00;
            rd_known = 1'b0;
         end
      endcase
   end

   // ------------------------------------------------------------
   // axi4-lite handshakes
   // ------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `WRT_RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `WRT_RESP_OKAY;
         s_axi_rdata <= 32'h0000_0000;
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= 4'h0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end else begin
         // capture each write channel independently, either order
         if (s_axi_awvalid & s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         s_axi_awready <= ~aw_held_r & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
         s_axi_wready <= ~w_held_r & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
         // held halves are freed when the response is raised
         if (aw_held_r & w_held_r & ~s_axi_bvalid) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? `WRT_RESP_OKAY : `WRT_RESP_SLVERR;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         // read: one outstanding; arready returns as soon as the data has
         // gone and never waits for arvalid to drop, which would stall
         if (rd_go | s_axi_rvalid) begin
            s_axi_arready <= 1'b0;
         end else begin
            s_axi_arready <= 1'b1;
         end
         if (rd_go) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rd_byte};
            s_axi_rresp <= rd_known ? `WRT_RESP_OKAY : `WRT_RESP_SLVERR;
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // synchronisers for the pin and the fixed clock
   // ------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         ext_sync_r <= 3'b000;
         fix_sync_r <= 3'b000;
      end else begin
         // only stage two and the edge stage feed logic
         ext_sync_r <= {ext_sync_r[1:0], external_count_input}; // [R22] [R20]
         fix_sync_r <= {fix_sync_r[1:0], fixed_frequency_clock};
      end
   end

   // ------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         overflow_irq_enable_r <= 1'b0; // [R4]
         counter_halt_bit_r <= `WRT_RST_HALT; // [R8]
         count_source_select_r <= `WRT_RST_SRC; // [R12]
         prescale_select_r <= `WRT_RST_PS; // [R16]
         wrap_limit_value_r <= `WRT_RST_WRAP; // [R18]
      end else begin
         // bit 5 is a strobe only and is kept nowhere
         if (wr_sc) begin
            overflow_irq_enable_r <= wr_data[`WRT_BIT_OVF_IRQ_EN];
            counter_halt_bit_r <= wr_data[`WRT_BIT_HALT]; // [R7]
         end
         if (wr_clk) begin
            // count_r untouched here on purpose
            count_source_select_r <= wr_data[`WRT_SRC_HI:`WRT_SRC_LO]; // [R11]
            prescale_select_r <= wr_data[`WRT_PS_HI:`WRT_PS_LO]; // [R15]
         end
         if (wr_mod) begin
            wrap_limit_value_r <= wr_data[7:0];
         end
      end
   end

   // ------------------------------------------------------------
   // counter, prescaler, overflow flag and interrupt
   // ------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         count_r <= `WRT_RST_COUNT; // [R19]
         prescale_r <= {PS_WIDTH{1'b0}};
         overflow_flag_r <= 1'b0;
         clear_armed_r <= 1'b0;
         overflow_irq <= 1'b0;
      end else begin
         // explicit resets restart the prescaler too, so the next period is whole
         if (cnt_reset | wr_mod) begin
            count_r <= 8'h00; // [R6] [R18]
            prescale_r <= {PS_WIDTH{1'b0}};
         end else begin
            if (src_tick & ~counter_halt_bit_r) begin
               prescale_r <= prescale_inc;
            end
            if (wrap_now) begin
               count_r <= 8'h00; // [R17]
            end else if (count_tick) begin
               count_r <= count_r + 8'h01;
            end
         end
         // set wins over the two-step clear; explicit resets win over set
         if (cnt_reset | wr_mod) begin
            overflow_flag_r <= 1'b0; // [R3]
         end else if (wrap_now) begin
            overflow_flag_r <= 1'b1; // [R1] [R21]
         end else if (flag_clear) begin
            overflow_flag_r <= 1'b0; // [R2]
         end
         // a new overflow disarms the pending clear
         if (wrap_now | wr_sc | cnt_reset | wr_mod) begin
            clear_armed_r <= 1'b0; // [R21]
         end else if (rd_sc & overflow_flag_r) begin
            clear_armed_r <= 1'b1; // [R2]
         end
         // software is expected to clear flag before enabling [R5]
         overflow_irq <= overflow_irq_enable_r & overflow_flag_r; // [R4]
      end
   end

endmodule
`default_nettype wire

// file: wrt_wrap_timer_chk.sv
// bus and read-field assertions for the wrap timer
`timescale 1ns/1ns
`default_nettype none
module wrt_wrap_timer_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic overflow_irq
);
   logic [3:0] ra_r;
   // ---------------------------------------------
   // address of the read in flight, for field checks
   // ---------------------------------------------
   always @(posedge aclk) begin
      if (s_axi_arvalid && s_axi_arready) begin
         ra_r <= s_axi_araddr;
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
      else $error("read answer late");
   a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");
   a_busy_refuse: assert property ((s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) and (s_axi_rvalid |-> !s_axi_arready))
      else $error("request accepted while busy");
   a_ar_recover: assert property (!s_axi_rvalid && !s_axi_arready |=> s_axi_arready)
      else $error("read address channel stalled");
   a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   a_status_zero: assert property (s_axi_rvalid && ra_r == 4'h0 |-> s_axi_rdata[5] == 1'b0 && s_axi_rdata[3:0] == 4'h0)
      else $error("status unused bits not zero");
   a_config_zero: assert property (s_axi_rvalid && ra_r == 4'h4 |-> s_axi_rdata[7:6] == 2'h0)
      else $error("config unused bits not zero");
   a_unmapped_err: assert property (s_axi_rvalid && ra_r[1:0] != 2'h0 |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !overflow_irq)
      else $error("outputs active after reset");
endmodule
bind wrt_wrap_timer wrt_wrap_timer_chk i_chk (.*);
`default_nettype wire

// file: wrt_wrap_timer_tb_top.sv
// self-checking bench for the wrap timer
`timescale 1ns/1ns
`default_nettype none
`include "wrt_regs.vh"
module wrt_wrap_timer_tb_top;
   localparam logic [3:0] a_sc = `WRT_OFF_STATUS_CONTROL;
   localparam logic [3:0] a_ck = `WRT_OFF_CLOCK_CONFIG;
   localparam logic [3:0] a_cn = `WRT_OFF_COUNT_VALUE;
   localparam logic [3:0] a_lm = `WRT_OFF_WRAP_LIMIT;
   logic aclk = 0, aresetn = 0, aw_v = 0, w_v = 0, b_rdy = 0, ar_v = 0, r_rdy = 0, ffc = 0, ext = 0;
   logic aw_r, w_r, b_v, ar_r, r_v, irq;
   logic [3:0] aw_a = 0, ar_a = 0;
   logic [31:0] w_d = 0, r_d;
   logic [1:0] b_resp, r_resp;
   logic [16:0] rnd = 17'h1_0bf9;
   logic [2:0] ph = 0;
   logic [17:0] exp_r[$];
   logic [1:0] exp_b[$];
   int err_total = 0, n_tests = 0, cyc = 0;
   wrt_wrap_timer i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v),
      .s_axi_awready(aw_r), .s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
      .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_rdy), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
      .s_axi_arready(ar_r), .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_rdy),
      .fixed_frequency_clock(ffc), .external_count_input(ext), .overflow_irq(irq));
   initial begin
      forever #5 aclk = ~aclk;
   end
   // slow sources at an eighth of the bus clock, inside the quarter limit
   always @(posedge aclk) begin
      ph <= ph + 3'h1;
      ffc <= ph[2];
      ext <= ~ph[2];
   end
   function automatic logic [16:0] lfsr(input logic [16:0] s);
      lfsr = {s[15:0], s[16] ^ s[13]};
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      n_tests++;
      if (s !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   // range check, since a running count is only known within a few edges
   task automatic chk_rd(input logic [17:0] e, input logic [31:0] d, input logic [1:0] r);
      chk("rresp", {30'h0, e[17:16]}, {30'h0, r});
      n_tests++;
      if ($isunknown(d) || d[31:8] !== 24'h0 || d[7:0] < e[15:8] || d[7:0] > e[7:0]) begin
         err_total++;
         $display("CHECK FAILED rdata expected %h..%h seen %h", e[15:8], e[7:0], d);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r);
      logic pa, pw, pb;
      exp_b.push_back(r);
      @(posedge aclk);
      rnd = lfsr(rnd);
      aw_a <= a;
      w_d <= {rnd[15:0], 8'h00, d};
      aw_v <= 1'b1;
      w_v <= 1'b1;
      b_rdy <= 1'b1;
      pa = 1;
      pw = 1;
      pb = 1;
      while (pa || pw || pb) begin
         @(posedge aclk);
         if (pa && aw_r) aw_v <= 1'b0;
         if (pw && w_r) w_v <= 1'b0;
         if (pb && b_v) b_rdy <= 1'b0;
         pa = pa && !aw_r;
         pw = pw && !w_r;
         pb = pb && !b_v;
      end
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] lo, input logic [7:0] hi, input logic [1:0] r);
      logic pa, pr;
      exp_r.push_back({r, lo, hi});
      @(posedge aclk);
      ar_a <= a;
      ar_v <= 1'b1;
      r_rdy <= 1'b1;
      pa = 1;
      pr = 1;
      while (pa || pr) begin
         @(posedge aclk);
         if (pa && ar_r) ar_v <= 1'b0;
         if (pr && r_v) r_rdy <= 1'b0;
         pa = pa && !ar_r;
         pr = pr && !r_v;
      end
   endtask
   // one timed run from zero, then halt and read the count
   task automatic run(input logic [1:0] s, input logic [3:0] p, input int w, input logic [7:0] lo, input logic [7:0] hi);
      wr(a_lm, 8'h00, 2'h0);
      wr(a_ck, {2'h0, s, p}, 2'h0);
      wr(a_sc, 8'h00, 2'h0);
      repeat (w) @(posedge aclk);
      wr(a_sc, 8'h10, 2'h0);
      rd(a_cn, lo, hi, 2'h0);
   endtask
   task automatic complete_run();
      $display("mismatches %0d of %0d checks", err_total, n_tests);
      if (err_total == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // watcher: each answer against the oldest note
   always @(posedge aclk) begin
      if (r_v && r_rdy) chk_rd(exp_r.pop_front(), r_d, r_resp);
      if (b_v && b_rdy) chk("bresp", {30'h0, exp_b.pop_front()}, {30'h0, b_resp});
   end
   // hang guard, well above the planned run length
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 60000) begin
         err_total++;
         complete_run();
      end
   end
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rd(a_sc, 8'h10, 8'h10, 2'h0);
      rd(a_ck, 8'h00, 8'h00, 2'h0);
      rd(a_lm, 8'h00, 8'h00, 2'h0);
      rd(4'h2, 8'h00, 8'h00, 2'h2);
      wr(4'h2, 8'h5a, 2'h2);
      wr(a_cn, rnd[7:0] | 8'h01, 2'h0);
      rd(a_cn, 8'h00, 8'h00, 2'h0);
      wr(a_ck, 8'hff, 2'h0);
      rd(a_ck, 8'h3f, 8'h3f, 2'h0);
      for (int s = 1; s < 4; s++) run(s[1:0], 4'h0, 320, 8'd38, 8'd43);
      for (int p = 0; p < 10; p++) run(2'h0, p[3:0], 40 << (p > 8 ? 8 : p), 8'd39, 8'd49);
      run(2'h0, 4'hf, 10240, 8'd39, 8'd49);
      wr(a_sc, 8'h00, 2'h0);
      repeat (20) @(posedge aclk);
      wr(a_ck, 8'h38, 2'h0);
      wr(a_sc, 8'h10, 2'h0);
      // count of the last run is kept across the source and prescale change
      rd(a_cn, 8'd39, 8'd49, 2'h0);
      wr(a_ck, 8'h00, 2'h0);
      wr(a_lm, 8'h04, 2'h0);
      wr(a_sc, 8'h40, 2'h0);
      repeat (20) @(posedge aclk);
      chk("irq", 32'h1, {31'h0, irq});
      wr(a_sc, 8'h50, 2'h0);
      rd(a_sc, 8'hd0, 8'hd0, 2'h0);
      wr(a_sc, 8'h50, 2'h0);
      rd(a_sc, 8'h50, 8'h50, 2'h0);
      repeat (2) @(posedge aclk);
      chk("irq", 32'h0, {31'h0, irq});
      rd(a_cn, 8'h00, 8'h04, 2'h0);
      wr(a_sc, 8'h70, 2'h0);
      repeat (20) @(posedge aclk);
      rd(a_cn, 8'h00, 8'h00, 2'h0);
      // flag set again, then cleared by counter reset, then by a limit write
      // a clear racing a wrap (one every five ticks) must leave the flag set
      for (int k = 0; k < 2; k++) begin
         wr(a_sc, 8'h00, 2'h0);
         repeat (20) @(posedge aclk);
         rd(a_sc, 8'h80, 8'h80, 2'h0);
         wr(a_sc, 8'h10, 2'h0);
         rd(a_sc, 8'h90, 8'h90, 2'h0);
         if (k == 0) wr(a_sc, 8'hb0, 2'h0);
         else wr(a_lm, 8'h04, 2'h0);
         rd(a_sc, 8'h10, 8'h10, 2'h0);
         rd(a_cn, 8'h00, 8'h00, 2'h0);
      end
      repeat (5) @(posedge aclk);
      complete_run();
   end
endmodule
`default_nettype wire
